// *** verilog/irq_enable_pkg.sv ***
// Purpose: constants and types for the interrupt enable register block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: register offsets are local choices
//
// Behaviour
// - First enable bits 15, 14, 13 are read/write and reset to 0.
// - First enable bits 4..0 are read/write and bits 12..5 read 0.
// - Third enable bit 14 is a read/write calendar enable, reset 0.
// - An enable bit at 1 lets its peripheral request through.
// - An enable bit at 0 blocks its peripheral request.
// - Third enable bits 15 and 13..0 read 0 and ignore writes.
package irq_enable_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFFS_ENABLE_FIRST = 8'h00;
  localparam logic [7:0] OFFS_ENABLE_THIRD = 8'h04;
  localparam logic [15:0] MASK_ENABLE_FIRST = 16'hE01F;
  localparam logic [15:0] MASK_ENABLE_THIRD = 16'h4000;
  localparam logic [15:0] RESET_ENABLE = 16'h0000;
  localparam int POS_UART_B_TX = 15;
  localparam int POS_UART_B_RX = 14;
  localparam int POS_EXT_PIN_B = 13;
  localparam int POS_EXT_PIN_A = 4;
  localparam int POS_PIN_CHANGE = 3;
  localparam int POS_COMPARATOR = 2;
  localparam int POS_I2C_MASTER = 1;
  localparam int POS_I2C_SLAVE = 0;
  localparam int POS_CALENDAR = 14;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic uart_b_tx;
    logic uart_b_rx;
    logic ext_pin_b;
    logic ext_pin_a;
    logic pin_change;
    logic comparator;
    logic i2c_master_event;
    logic i2c_slave_event;
    logic calendar_clock;
  } irq_vec_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_resp_t;
endpackage

// *** verilog/irq_enable_regs.sv ***
// Purpose: two interrupt enable registers gating peripheral requests
// Assumes: flags held elsewhere; peripheral flags are on pclk
// Notes: zero wait state apb; unmapped address answers pslverr
`timescale 1ns/1ps
module irq_enable_regs
  import irq_enable_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire irq_vec_t irq_flag,
  output irq_vec_t irq_req
);
  // ****************************************
  // register state
  // ****************************************
  logic [15:0] enable_first_r, enable_first_nxt;
  logic [15:0] enable_third_r, enable_third_nxt;
  apb_resp_t resp_r, resp_nxt;
  irq_vec_t req_r, req_nxt;
  logic setup;
  logic hit_first;
  logic hit_third;
  logic [15:0] wdata16;
  localparam int NUM_REQ = $bits(irq_vec_t);
  logic access;
  logic wr_commit;
  logic miss;
  logic [31:0] rd_word;
  logic [15:0] first_wmask;
  logic [15:0] third_wmask;
  logic [15:0] first_view;
  logic [15:0] third_view;
  logic [NUM_REQ-2:0] gate_first;
  logic gate_third;
  logic [NUM_REQ-1:0] flag_vec;
  logic [NUM_REQ-1:0] gate_vec;
  logic [NUM_REQ-1:0] req_vec_nxt;

  // ****************************************
  // helpers
  // ****************************************

  // byte lanes 0 and 1 carry the 16-bit register
  function automatic logic [15:0] lane_mask(
      input logic [3:0] strb
  );
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // a lane left low keeps its old byte
  function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] wd,
      input logic [15:0] m
  );
    merge = (old & ~m) | (wd & m);
  endfunction

  // bits 31:16 always read 0, and a miss reads 0 as well
  function automatic logic [31:0] read_word(
      input logic sel_first,
      input logic sel_third,
      input logic [15:0] first,
      input logic [15:0] third
  );
    read_word = 32'h00000000;
    if (sel_first) begin
      read_word = {16'h0000, first};
    end else if (sel_third) begin
      read_word = {16'h0000, third};
    end
  endfunction

  // ****************************************
  // access decode
  // ****************************************
  assign setup = psel & ~penable;
  assign access = psel & penable;
  // a write lands only on the edge that samples pready high
  assign wr_commit = access & resp_r.pready & pwrite;
  // exact decode: aliases would hide software address faults
  assign hit_first = paddr == OFFS_ENABLE_FIRST;
  assign hit_third = paddr == OFFS_ENABLE_THIRD;
  assign miss = ~(hit_first | hit_third);
  // lanes 2 and 3 have nothing to write
  assign wdata16 = pwdata[15:0];

  // ****************************************
  // write masks
  // ****************************************
  // unimplemented bits are masked out, so writes to them are lost
  assign first_wmask = lane_mask(pstrb) & MASK_ENABLE_FIRST;
  assign third_wmask = lane_mask(pstrb) & MASK_ENABLE_THIRD;

  // ****************************************
  // enable registers
  // ****************************************
  always_comb begin
    enable_first_nxt = enable_first_r;
    enable_third_nxt = enable_third_r;

    if (wr_commit && hit_first) begin
      enable_first_nxt = merge(enable_first_r, wdata16,
        first_wmask);
    end

    if (wr_commit && hit_third) begin
      enable_third_nxt = merge(enable_third_r, wdata16,
        third_wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_first_r <= RESET_ENABLE;
      enable_third_r <= RESET_ENABLE;
    end else begin
      enable_first_r <= enable_first_nxt;
      enable_third_r <= enable_third_nxt;
    end
  end

  // ****************************************
  // read view
  // ****************************************
  // only implemented bits are ever seen by software
  assign first_view = enable_first_r & MASK_ENABLE_FIRST;
  assign third_view = enable_third_r & MASK_ENABLE_THIRD;
  assign rd_word = read_word(hit_first, hit_third, first_view, third_view);

  // ****************************************
  // apb response
  // ****************************************
  // answer prepared in setup so pready rises with penable
  always_comb begin
    resp_nxt = '0;
    if (setup) begin
      resp_nxt.pready = 1'b1;
      resp_nxt.pslverr = miss;
      if (!pwrite) begin
        resp_nxt.prdata = rd_word;
      end
    end
  end

  // reset clears the answer so no stale pready survives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_r <= '0;
    end else begin
      resp_r <= resp_nxt;
    end
  end

  // ****************************************
  // request gating
  // ****************************************
  // enables are only read here, so the stored flags never change
  assign flag_vec = irq_flag;
  assign gate_first = {
    enable_first_r[POS_UART_B_TX],
    enable_first_r[POS_UART_B_RX],
    enable_first_r[POS_EXT_PIN_B],
    enable_first_r[POS_EXT_PIN_A],
    enable_first_r[POS_PIN_CHANGE],
    enable_first_r[POS_COMPARATOR],
    enable_first_r[POS_I2C_MASTER],
    enable_first_r[POS_I2C_SLAVE]
  };
  assign gate_third = enable_third_r[POS_CALENDAR];
  // field order of irq_vec_t, calendar clock last
  assign gate_vec = {gate_first, gate_third};

  generate
    for (genvar i = 0; i < NUM_REQ; i++) begin : g_gate
      assign req_vec_nxt[i] = flag_vec[i] & gate_vec[i];
    end
  endgenerate

  // the cast relies on gate_vec following the struct field order
  always_comb begin
    req_nxt = irq_vec_t'(req_vec_nxt);
  end

  // a registered request costs one cycle but cannot glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output comes straight from a flop
  assign prdata = resp_r.prdata;
  assign pready = resp_r.pready;
  assign pslverr = resp_r.pslverr;
  assign irq_req = req_r;
endmodule

// *** testbench/irq_enable_properties.sv ***
// Purpose: port assertions for the enable registers
// Assumes: one clock, async active low reset
// Notes: enables are internal, so gating shows only via irq_req
`timescale 1ns/1ps
module irq_chk import irq_enable_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire irq_vec_t irq_flag,
  input wire irq_vec_t irq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rst_quiet_a: assert property ($rose(presetn) |-> irq_req == '0)
    else $error("req after reset");
  req_flag_a: assert property ((irq_req & ~$past(irq_flag)) == '0)
    else $error("req without flag");
  req_hold_a: assert property ($stable(irq_flag) && !$past(pready)
    |=> $stable(irq_req)) else $error("req moved");
  upper_zero_a: assert property (pready |-> prdata[31:16] == '0)
    else $error("upper half set");
  err_ack_a: assert property (pslverr |-> pready && prdata == '0)
    else $error("bad error reply");
  first_rd_a: assert property (pready && paddr == OFFS_ENABLE_FIRST
    |-> prdata[15:0] == (prdata[15:0] & MASK_ENABLE_FIRST))
    else $error("first reg bits");
  third_rd_a: assert property (pready && paddr == OFFS_ENABLE_THIRD
    |-> prdata[15:0] == (prdata[15:0] & MASK_ENABLE_THIRD))
    else $error("third reg bits");
endmodule
bind irq_enable_regs irq_chk u_chk(.pclk, .presetn, .paddr, .prdata,
  .pready, .pslverr, .irq_flag, .irq_req);

// *** testbench/testbench.sv ***
// Purpose: apb tests of the enable registers
// Assumes: master waits for pready, offsets from the package
// Notes: strobes tied full, so lane masking goes unchecked
`timescale 1ns/1ps
module testbench;
  import irq_enable_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  irq_vec_t irq_flag = 9'h1FF, irq_req;
  int num_errors = 0, check_count = 0;
  always #5 pclk = ~pclk;
  irq_enable_regs DUT(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .irq_flag, .irq_req);
  task chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    logic miss;
    miss = (a != OFFS_ENABLE_FIRST) && (a != OFFS_ENABLE_THIRD);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) chk("prdata", e, prdata);
    chk("pslverr", {31'h0, miss}, {31'h0, pslverr});
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task final_report;
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #3000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'h0, 8'h00, 32'h0, 32'h0);
    chk("irq_req", 32'h0, 32'(irq_req));
    xfer(1'h1, 8'h00, 32'hFFFFFFFF, 32'h0);
    xfer(1'h0, 8'h00, 32'h0, 32'hE01F);
    xfer(1'h1, 8'h04, 32'hFFFFFFFF, 32'h0);
    xfer(1'h0, 8'h04, 32'h0, 32'h4000);
    chk("irq_req", 32'h1FF, 32'(irq_req));
    xfer(1'h1, 8'h00, 32'h12, 32'h0);
    irq_flag <= 9'h0F0;
    xfer(1'h0, 8'h08, 32'h0, 32'h0);
    xfer(1'h0, 8'h00, 32'h0, 32'h12);
    chk("irq_req", 32'h20, 32'(irq_req));
    final_report();
  end
endmodule
